// [dcs_pkg.sv]
`default_nettype none

package dcs_pkg;

    // *****************************************************************
    // Sizes
    // *****************************************************************
    localparam int          DCS_NUM_CH     = 8;
    localparam int          DCS_CH_W       = 3;
    localparam int          DCS_ADDR_W     = 16;
    localparam int          DCS_BUS_AW     = 5;
    localparam int          DCS_IRQ_W      = 3;

    // *****************************************************************
    // Register byte offsets
    // *****************************************************************
    localparam logic [4:0]  DCS_OFF_COLL   = 5'h00;
    localparam logic [4:0]  DCS_OFF_STATE  = 5'h04;
    localparam logic [4:0]  DCS_OFF_ADDR   = 5'h08;
    localparam logic [4:0]  DCS_OFF_ISTAT  = 5'h0C;
    localparam logic [4:0]  DCS_OFF_IMASK  = 5'h10;

    // *****************************************************************
    // Field positions
    // *****************************************************************
    localparam int          DCS_PCOL_LSB   = 8;
    localparam int          DCS_RCOL_LSB   = 0;
    localparam int          DCS_LAST_LSB   = 8;
    localparam int          DCS_BUF_LSB    = 0;
    localparam int          DCS_IRQ_PCOL   = 0;
    localparam int          DCS_IRQ_RCOL   = 1;
    localparam int          DCS_IRQ_DONE   = 2;

    // *****************************************************************
    // Reset values
    // *****************************************************************
    localparam logic [15:0] DCS_COLL_RST   = 16'h0000;
    localparam logic [3:0]  DCS_LAST_ACTIVE_CHANNEL_RST  = 4'hF;
    localparam logic        DCS_BUF_RST    = 1'b0;
    localparam logic [15:0] DCS_ADDR_RST   = 16'h0000;
    localparam logic [2:0]  DCS_IRQ_RST    = 3'h0;
    localparam logic [31:0] DCS_RDATA_RST  = 32'h0000_0000;

    // *****************************************************************
    // Channel operating modes
    // *****************************************************************
    typedef enum logic [1:0] {
        DCS_MODE_CONT       = 2'b00,
        DCS_MODE_ONESHOT    = 2'b01,
        DCS_MODE_PP_CONT    = 2'b10,
        DCS_MODE_PP_ONESHOT = 2'b11
    } dcs_mode_t;

endpackage

`default_nettype wire

// [dcs_pingpong.sv]
`timescale 1ns/1ps
`default_nettype none

module dcs_pingpong
    import dcs_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Channel control
    input  wire logic [1:0] mode,
    input  wire logic       block_done,
    // Buffer select
    output var  logic       status
);

    logic pp_mode;

    always_comb begin
        pp_mode = (mode == DCS_MODE_PP_CONT) || (mode == DCS_MODE_PP_ONESHOT); // R8
    end

    // *****************************************************************
    // Buffer select flip-flop
    // *****************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            status <= DCS_BUF_RST; // R5
        end else if (block_done && pp_mode) begin
            status <= ~status; // R8
        end
    end

    AST_PP_TOGGLE: assert property ( // R8
        @(posedge clk) disable iff (rst)
        (block_done && mode[1]) |=> (status != $past(status))
    ) else $error("buffer select did not alternate");

    AST_PP_HOLD: assert property ( // R8
        @(posedge clk) disable iff (rst)
        !(block_done && mode[1]) |=> $stable(status)
    ) else $error("buffer select changed outside a ping-pong block end");

    AST_PP_RESET: assert property ( // R5
        @(posedge clk) disable iff (rst)
        $fell(rst) |-> (status == 1'b0)
    ) else $error("buffer select not primary after reset");

endmodule

`default_nettype wire

// [dcs_status.sv]
// Contract
// R1: Sticky per-channel peripheral write collision flags, upper byte
// R2: Sticky per-channel RAM write collision flags, lower byte
// R3: Last channel field resets to all ones
// R4: Each transfer loads last channel number 0-7
// R5: Per-channel buffer select bit, resets to primary
// R6: Register holds most recent RAM address accessed
// R7: Upper four bits of channel state read zero
// R8: Buffer select toggles only in ping-pong modes
// R9: Same-cycle DMA and processor write flags collision
//
// The Avalon-MM interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module dcs_status
    import dcs_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // Avalon-MM slave
    input  wire logic [4:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output var  logic [31:0] AVS_READDATA,
    output var  logic        AVS_WAITREQUEST,
    // Transfer engine events
    input  wire logic        XFER_DONE,
    input  wire logic [2:0]  XFER_CHANNEL,
    input  wire logic [7:0]  BLOCK_DONE,
    input  wire logic [15:0] CH_MODE,
    // DMA bus activity
    input  wire logic [2:0]  DMA_CHANNEL,
    input  wire logic        DMA_PERIPH_WR,
    input  wire logic [15:0] DMA_PERIPH_ADDR,
    input  wire logic        DMA_RAM_ACC,
    input  wire logic        DMA_RAM_WR,
    input  wire logic [15:0] DMA_RAM_ADDR,
    // Processor bus activity
    input  wire logic        CPU_PERIPH_WR,
    input  wire logic [15:0] CPU_PERIPH_ADDR,
    input  wire logic        CPU_RAM_WR,
    input  wire logic [15:0] CPU_RAM_ADDR,
    // Interrupt
    output var  logic        IRQ
);

    // *****************************************************************
    // Declarations
    // *****************************************************************
    logic [7:0]  periph_flag;
    logic [7:0]  ram_flag;
    logic [3:0]  last_ch;
    logic [7:0]  buf_sel;
    logic [15:0] coll_flags;
    logic [15:0] recent_addr;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
    logic        periph_hit;
    logic        ram_hit;
    logic [7:0]  periph_set;
    logic [7:0]  ram_set;
    logic [2:0]  irq_event;
    logic        bus_req;
    logic        bus_ack;
    logic        wr_en;
    logic [15:0] be_mask;
    logic [15:0] coll_clr;
    logic [2:0]  irq_clr;
    logic [31:0] next_rdata;

    function automatic logic [7:0] chan_onehot(input logic [2:0] ch);
        chan_onehot = 8'h01 << ch;
    endfunction

    // *****************************************************************
    // Collision detection
    // *****************************************************************
    always_comb begin
        periph_hit = DMA_PERIPH_WR && CPU_PERIPH_WR
                     && (DMA_PERIPH_ADDR == CPU_PERIPH_ADDR); // R9
        ram_hit    = DMA_RAM_WR && CPU_RAM_WR
                     && (DMA_RAM_ADDR == CPU_RAM_ADDR); // R9
        periph_set = periph_hit ? chan_onehot(DMA_CHANNEL) : 8'h00; // R9
        ram_set    = ram_hit ? chan_onehot(DMA_CHANNEL) : 8'h00; // R9
        irq_event  = {XFER_DONE, ram_hit, periph_hit};
    end

    // *****************************************************************
    // Bus slave
    // *****************************************************************
    always_comb begin
        bus_req  = AVS_READ || AVS_WRITE;
        bus_ack  = bus_req && !AVS_WAITREQUEST;
        wr_en    = AVS_WRITE && bus_ack;
        be_mask  = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
        coll_clr = (wr_en && AVS_ADDRESS == DCS_OFF_COLL)
                   ? (AVS_WRITEDATA[15:0] & be_mask) : 16'h0000;
        irq_clr  = (wr_en && AVS_ADDRESS == DCS_OFF_ISTAT)
                   ? (AVS_WRITEDATA[2:0] & {3{AVS_BYTEENABLE[0]}}) : 3'h0;
    end

    // One wait state: waitrequest drops for one cycle per request
    always_ff @(posedge CLK) begin
        if (RST) begin
            AVS_WAITREQUEST <= 1'b1;
        end else if (bus_req && AVS_WAITREQUEST) begin
            AVS_WAITREQUEST <= 1'b0;
        end else begin
            AVS_WAITREQUEST <= 1'b1;
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (AVS_ADDRESS)
            DCS_OFF_COLL: begin
                next_rdata[15:0] = coll_flags;
            end
            DCS_OFF_STATE: begin
                next_rdata[15:0] = {4'h0, last_ch, buf_sel}; // R7
            end
            DCS_OFF_ADDR: begin
                next_rdata[15:0] = recent_addr;
            end
            DCS_OFF_ISTAT: begin
                next_rdata[2:0] = irq_stat;
            end
            DCS_OFF_IMASK: begin
                next_rdata[2:0] = irq_mask;
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            AVS_READDATA <= DCS_RDATA_RST;
        end else if (AVS_READ && AVS_WAITREQUEST) begin
            AVS_READDATA <= next_rdata;
        end
    end

    // *****************************************************************
    // Collision flags
    // *****************************************************************
    // A new collision wins over a clear in the same cycle
    always_ff @(posedge CLK) begin
        if (RST) begin
            periph_flag <= DCS_COLL_RST[15:8];
        end else begin
            periph_flag <= (periph_flag & ~coll_clr[15:8]) | periph_set; // R1
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            ram_flag <= DCS_COLL_RST[7:0];
        end else begin
            ram_flag <= (ram_flag & ~coll_clr[7:0]) | ram_set; // R2
        end
    end

    always_comb begin
        coll_flags = {periph_flag, ram_flag};
    end

    // *****************************************************************
    // Channel state
    // *****************************************************************
    always_ff @(posedge CLK) begin
        if (RST) begin
            last_ch <= DCS_LAST_ACTIVE_CHANNEL_RST; // R3
        end else if (XFER_DONE) begin
            last_ch <= {1'b0, XFER_CHANNEL}; // R4
        end
    end

    generate
        for (genvar i = 0; i < DCS_NUM_CH; i++) begin : g_pp
            dcs_pingpong dcs_pingpong_i (
                .clk        (CLK),
                .rst        (RST),
                .mode       (CH_MODE[2*i +: 2]),
                .block_done (BLOCK_DONE[i]),
                .status     (buf_sel[i])
            );
        end
    endgenerate

    always_ff @(posedge CLK) begin
        if (RST) begin
            recent_addr <= DCS_ADDR_RST;
        end else if (DMA_RAM_ACC) begin
            recent_addr <= DMA_RAM_ADDR; // R6
        end
    end

    // *****************************************************************
    // Interrupts
    // *****************************************************************
    always_ff @(posedge CLK) begin
        if (RST) begin
            irq_stat <= DCS_IRQ_RST;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_event;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            irq_mask <= DCS_IRQ_RST;
        end else if (wr_en && AVS_ADDRESS == DCS_OFF_IMASK && AVS_BYTEENABLE[0]) begin
            irq_mask <= AVS_WRITEDATA[2:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(irq_stat & irq_mask);
        end
    end

    // *****************************************************************
    // Assertions
    // *****************************************************************
    AST_PERIPH_COL_SET: assert property ( // R1
        @(posedge CLK) disable iff (RST)
        periph_hit |=> periph_flag[$past(DMA_CHANNEL)]
    ) else $error("peripheral collision not flagged");

    AST_RAM_COL_SET: assert property ( // R2
        @(posedge CLK) disable iff (RST)
        ram_hit |=> ram_flag[$past(DMA_CHANNEL)]
    ) else $error("RAM collision not flagged");

    AST_COL_STICKY: assert property ( // R1
        @(posedge CLK) disable iff (RST)
        !(wr_en && AVS_ADDRESS == DCS_OFF_COLL)
        |=> ((coll_flags & $past(coll_flags)) == $past(coll_flags))
    ) else $error("collision flag dropped without a clear");

    AST_COL_CAUSE: assert property ( // R9
        @(posedge CLK) disable iff (RST)
        (!periph_hit && !ram_hit)
        |=> ((coll_flags & ~$past(coll_flags)) == 16'h0000)
    ) else $error("collision flag set with no collision");

    AST_COL_CLEAR: assert property ( // R2
        @(posedge CLK) disable iff (RST)
        (!periph_hit && !ram_hit && coll_clr != 16'h0000)
        |=> ((coll_flags & $past(coll_clr)) == 16'h0000)
    ) else $error("collision flag not cleared by a written one");

    AST_LAST_CH_RESET: assert property ( // R3
        @(posedge CLK) disable iff (RST)
        $fell(RST) |-> (last_ch == 4'hF)
    ) else $error("last channel not all ones after reset");

    AST_LAST_CH_LOAD: assert property ( // R4
        @(posedge CLK) disable iff (RST)
        XFER_DONE |=> (last_ch == {1'b0, $past(XFER_CHANNEL)})
    ) else $error("last channel not loaded by transfer");

    AST_LAST_CH_CODE: assert property ( // R4
        @(posedge CLK) disable iff (RST)
        (last_ch[3] == 1'b0) || (last_ch == 4'hF)
    ) else $error("last channel holds a reserved code");

    AST_ADDR_LOAD: assert property ( // R6
        @(posedge CLK) disable iff (RST)
        DMA_RAM_ACC |=> (recent_addr == $past(DMA_RAM_ADDR))
    ) else $error("recent address not updated");

    AST_UNIMP_ZERO: assert property ( // R7
        @(posedge CLK) disable iff (RST)
        (AVS_READ && AVS_WAITREQUEST && AVS_ADDRESS == DCS_OFF_STATE)
        |=> (AVS_READDATA[31:12] == 20'h00000) && !AVS_WAITREQUEST
    ) else $error("unimplemented channel state bits read nonzero");

    AST_BUS_ACK: assert property (
        @(posedge CLK) disable iff (RST)
        (bus_req && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST
    ) else $error("waitrequest did not drop for exactly one cycle");

    AST_IRQ_SET: assert property (
        @(posedge CLK) disable iff (RST)
        (irq_event != 3'h0) |=> ((irq_stat & $past(irq_event)) == $past(irq_event))
    ) else $error("interrupt status missed an event");

    AST_IRQ_LEVEL: assert property (
        @(posedge CLK) disable iff (RST)
        1'b1 |=> (IRQ == |($past(irq_stat) & $past(irq_mask)))
    ) else $error("interrupt output does not follow status and mask");

endmodule

`default_nettype wire

// [test_dcs_status.sv]
`timescale 1ns/1ps
`default_nettype none

module test_dcs_status
    import dcs_pkg::*;
;
    // ************************************************
    // Stimulus and observed signals
    // ************************************************
    logic        clk;
    logic        rst;
    logic [4:0]  adr;
    logic        rd_en;
    logic        wr_en;
    logic [31:0] wdat;
    logic [3:0]  be;
    logic [31:0] rdat;
    logic        wait_req;
    logic        xdone;
    logic [2:0]  xch;
    logic [7:0]  blk;
    logic [15:0] mode;
    logic [2:0]  dch;
    logic        dpw;
    logic [15:0] dpa;
    logic        drac;
    logic        drw;
    logic [15:0] dra;
    logic        cpw;
    logic [15:0] cpa;
    logic        crw;
    logic [15:0] cra;
    logic        irq;
    logic [31:0] rd;
    int          num_errors;
    int          n_tests;

    dcs_status dcs_status_i (
        .CLK(clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd_en), .AVS_WRITE(wr_en),
        .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
        .AVS_WAITREQUEST(wait_req), .XFER_DONE(xdone), .XFER_CHANNEL(xch),
        .BLOCK_DONE(blk), .CH_MODE(mode), .DMA_CHANNEL(dch), .DMA_PERIPH_WR(dpw),
        .DMA_PERIPH_ADDR(dpa), .DMA_RAM_ACC(drac), .DMA_RAM_WR(drw), .DMA_RAM_ADDR(dra),
        .CPU_PERIPH_WR(cpw), .CPU_PERIPH_ADDR(cpa), .CPU_RAM_WR(crw), .CPU_RAM_ADDR(cra),
        .IRQ(irq)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ************************************************
    // Shared tasks
    // ************************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                       input logic [3:0] b);
        int n;
        n = 0;
        @(posedge clk);
        adr   <= a;
        wdat  <= d;
        be    <= b;
        rd_en <= !w;
        wr_en <= w;
        do begin
            @(posedge clk);
            n++;
        end while (wait_req !== 1'b0 && n < 50);
        if (n >= 50) chk("bus answer", 32'h0000_0000, 32'h0000_0001);
        rd = rdat;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
    endtask

    task automatic rchk(input string what, input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000, 4'h0);
        chk(what, exp, rd);
    endtask

    task automatic irq_chk(input logic exp);
        repeat (3) @(posedge clk);
        chk("irq", {31'h0, exp}, {31'h0, irq});
    endtask

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // ************************************************
    // Scenarios
    // ************************************************
    task automatic test_reset;
        rchk("coll", DCS_OFF_COLL, 32'h0000_0000);
        rchk("state", DCS_OFF_STATE, 32'h0000_0F00);
        rchk("addr", DCS_OFF_ADDR, 32'h0000_0000);
        rchk("istat", DCS_OFF_ISTAT, 32'h0000_0000);
        rchk("imask", DCS_OFF_IMASK, 32'h0000_0000);
        rchk("unmapped", 5'h14, 32'h0000_0000);
        $display("test_reset done");
    endtask

    task automatic test_collision;
        @(posedge clk);
        dch <= 3'h3;
        dpw <= 1'b1;
        cpw <= 1'b1;
        @(posedge clk);
        dpw  <= 1'b0;
        cpw  <= 1'b0;
        dch  <= 3'h5;
        drac <= 1'b1;
        drw  <= 1'b1;
        crw  <= 1'b1;
        @(posedge clk);
        dch <= 3'h6;
        cra <= 16'h0802;
        @(posedge clk);
        drac <= 1'b0;
        drw  <= 1'b0;
        crw  <= 1'b0;
        rchk("coll set", DCS_OFF_COLL, 32'h0000_0820);
        bus(1'b1, DCS_OFF_COLL, 32'h0000_0000, 4'h3);
        rchk("coll zero write", DCS_OFF_COLL, 32'h0000_0820);
        bus(1'b1, DCS_OFF_COLL, 32'h0000_FFFF, 4'h2);
        rchk("coll lane1 clear", DCS_OFF_COLL, 32'h0000_0020);
        bus(1'b1, DCS_OFF_STATE, 32'hFFFF_FFFF, 4'hF);
        rchk("state read only", DCS_OFF_STATE, 32'h0000_0F00);
        bus(1'b1, DCS_OFF_COLL, 32'h0000_00FF, 4'h1);
        rchk("coll lane0 clear", DCS_OFF_COLL, 32'h0000_0000);
        $display("test_collision done");
    endtask

    // Channel modes 00,01,10,11 twice over; only 10 and 11 alternate
    task automatic test_pingpong;
        mode <= 16'hE4E4;
        @(posedge clk);
        blk <= 8'hFF;
        @(posedge clk);
        blk <= 8'h00;
        rchk("pp one", DCS_OFF_STATE, 32'h0000_0FCC);
        @(posedge clk);
        blk <= 8'hFF;
        repeat (2) @(posedge clk);
        blk <= 8'h00;
        rchk("pp two", DCS_OFF_STATE, 32'h0000_0FCC);
        @(posedge clk);
        blk <= 8'hFF;
        @(posedge clk);
        blk <= 8'h00;
        rchk("pp three", DCS_OFF_STATE, 32'h0000_0F00);
        $display("test_pingpong done");
    endtask

    task automatic test_xfer;
        for (int c = 7; c >= 0; c--) begin
            @(posedge clk);
            xdone <= 1'b1;
            xch   <= c[2:0];
            @(posedge clk);
            xdone <= 1'b0;
            rchk("last ch", DCS_OFF_STATE, {20'h0, 1'b0, c[2:0], 8'h00});
        end
        @(posedge clk);
        drac <= 1'b1;
        dra  <= 16'hA5C3;
        @(posedge clk);
        drac <= 1'b0;
        dra  <= 16'h1111;
        rchk("recent addr", DCS_OFF_ADDR, 32'h0000_A5C3);
        bus(1'b1, DCS_OFF_ADDR, 32'h0000_FFFF, 4'hF);
        rchk("addr read only", DCS_OFF_ADDR, 32'h0000_A5C3);
        $display("test_xfer done");
    endtask

    task automatic test_irq;
        rchk("istat sticky", DCS_OFF_ISTAT, 32'h0000_0007);
        irq_chk(1'b0);
        bus(1'b1, DCS_OFF_IMASK, 32'h0000_0004, 4'h1);
        irq_chk(1'b1);
        bus(1'b1, DCS_OFF_ISTAT, 32'h0000_0007, 4'h1);
        irq_chk(1'b0);
        rchk("istat clear", DCS_OFF_ISTAT, 32'h0000_0000);
        @(posedge clk);
        xdone <= 1'b1;
        @(posedge clk);
        xdone <= 1'b0;
        irq_chk(1'b1);
        bus(1'b1, DCS_OFF_IMASK, 32'h0000_0000, 4'h1);
        irq_chk(1'b0);
        $display("test_irq done");
    endtask

    initial begin
        num_errors = 0;
        n_tests    = 0;
        rst = 1'b1;
        {adr, rd_en, wr_en, wdat, be, xdone, xch, blk, mode} = '0;
        {dch, dpw, drac, drw, cpw, crw} = '0;
        dpa = 16'h1234;
        cpa = 16'h1234;
        dra = 16'h0800;
        cra = 16'h0800;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        test_reset();
        test_collision();
        test_pingpong();
        test_xfer();
        test_irq();
        // Mid-run reset must restore every register
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        test_reset();
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        $display("MISMATCH watchdog expected finish seen hang");
        print_verdict();
    end
endmodule

`default_nettype wire
